// File: hdl/ptx_dma_ctl.sv
// Behaviour
// - controller reset holds engine, reloads next address, zeroes packets; other registers untouched
// - flush bit resets FIFO directly, independent
// - auto mode keeps address, enables packet count
// - reporting enable gives error acknowledge, no interrupt
// - abort interrupt on any abnormal packet end
// - normal-end interrupt on each good packet
// - run enable gates sending; clearing zeroes packets
// - upcoming address advances per beat, reloads
// - keep copy of last popped word
// - byte progress advances per beat, ends at size rounded down to whole words
// - auto mode: zero bytes, count packet
// - packet counter cleared by reset or run off
// - normal-end flag only for good packets
// - three bus-error flags, contents unchanged
// - FIFO fault flag follows FIFO error output
// - illegal-state flag, state returns to idle on the next clock
// - retry limit per transaction, flags excess
// - target and initiator abort flags, engine back to idle, address kept
// - flags sticky, write one clears
// - size write with run high starts packet
// - all-ones retry limit means unlimited
// - zero beats means eight; tail uses singles
// - whole words only, size low bits ignored
`timescale 1ns/1ps
`default_nettype none
module ptx_dma_ctl
  import ptx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // register bus
  input wire logic reg_sel_in,
  input wire logic reg_write_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [3:0] reg_byte_en_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic transfer_error_ack_n_out,
  // word stream from the sequencer
  input wire logic word_valid_in,
  input wire logic [ptx_pkg::PTX_WORD_W-1:0] word_data_in,
  output logic word_ready_out,
  // transmit FIFO side
  input wire logic fifo_fault_in,
  output logic fifo_flush_out,
  // PCI master controller
  output logic mst_req_out,
  output logic [3:0] mst_cmd_out,
  output logic [31:0] mst_addr_out,
  output logic [7:0] mst_beats_out,
  input wire logic mst_req_ready_in,
  output logic [31:0] mst_data_out,
  output logic mst_data_valid_out,
  input wire logic mst_data_ready_in,
  input wire logic mst_done_in,
  input wire logic mst_retry_in,
  input wire logic mst_target_abort_in,
  input wire logic mst_init_abort_in,
  // interrupt
  output logic irq_out
);
  import ptx_pkg::*;

  ptx_stream_if #(.W(PTX_WORD_W)) in_s ();
  ptx_stream_if #(.W(PTX_WORD_W)) out_s ();

  logic [15:0] pkt_size_reg;
  logic [31:0] start_addr_reg;
  logic [3:0] cmd_reg;
  logic [7:0] max_retry_reg;
  logic [7:0] max_beats_reg;
  logic ctl_reset_reg;
  logic fifo_flush_reg;
  logic auto_addr_reg;
  logic berr_en_reg;
  logic abort_ie_reg;
  logic normal_ie_reg;
  logic run_en_reg;
  logic [31:0] next_addr_reg;
  logic [31:0] last_word_reg;
  logic [15:0] bytes_done_reg;
  logic [15:0] packets_done_reg;
  logic [PTX_FLAG_N-1:0] flag_reg;
  logic [PTX_FLAG_N-1:0] flag_set;
  logic [PTX_FLAG_N-1:0] flag_clr;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic tea_n_reg;
  logic irq_reg;
  ptx_state_e state_reg;
  logic [7:0] beats_left_reg;
  logic [31:0] word_reg;
  logic word_valid_reg;
  logic pending_reg;
  logic in_win;
  logic hit_rw;
  logic hit_ro;
  logic hit_rsv;
  logic bad_access;
  logic wr_ok;
  logic [31:0] be_mask;
  logic [15:0] remaining;
  logic [15:0] left_after;
  logic [7:0] burst_beats;
  logic [7:0] plan_beats;
  logic beat_ok;
  logic pop;
  logic start_go;
  logic abort_evt;
  logic retry_evt;
  logic retry_over;
  logic state_bad;
  logic active;

  // register decode
  assign in_win = reg_addr_in[15:PTX_WIN_LSB] == PTX_OFS_PKT_SIZE[15:PTX_WIN_LSB];
  assign hit_rw = (reg_addr_in == PTX_OFS_PKT_SIZE) || (reg_addr_in == PTX_OFS_START_ADDR)
                  || (reg_addr_in == PTX_OFS_XACT_CTL) || (reg_addr_in == PTX_OFS_ENABLES)
                  || (reg_addr_in == PTX_OFS_FLAGS);
  assign hit_ro = (reg_addr_in == PTX_OFS_NEXT_ADDR) || (reg_addr_in == PTX_OFS_LAST_WORD)
                  || (reg_addr_in == PTX_OFS_COUNTS);
  assign hit_rsv = in_win && !hit_rw && !hit_ro;
  assign bad_access = reg_sel_in && ((reg_write_in && (hit_ro || hit_rsv)) || hit_rsv);
  assign wr_ok = reg_sel_in && reg_write_in && hit_rw;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_be
      assign be_mask[gi*8 +: 8] = {8{reg_byte_en_in[gi]}};
    end
  endgenerate

  // answer one cycle after the request
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ack_reg <= 1'b0;
      tea_n_reg <= 1'b1;
    end
    else
    begin
      ack_reg <= reg_sel_in && !(bad_access && berr_en_reg);
      tea_n_reg <= !(bad_access && berr_en_reg);
    end
  end

  always_comb
  begin
    rdata_next = PTX_ZERO_RESET;
    if (reg_addr_in == PTX_OFS_PKT_SIZE)
      rdata_next[PTX_PKT_SIZE_LSB +: 16] = pkt_size_reg;
    else if (reg_addr_in == PTX_OFS_START_ADDR)
      rdata_next = start_addr_reg;
    else if (reg_addr_in == PTX_OFS_XACT_CTL)
      rdata_next = {4'h0, cmd_reg, max_retry_reg, max_beats_reg, 8'h00};
    else if (reg_addr_in == PTX_OFS_ENABLES)
      rdata_next[31:24] = {ctl_reset_reg, fifo_flush_reg, 1'b0, auto_addr_reg,
                           berr_en_reg, abort_ie_reg, normal_ie_reg, run_en_reg};
    else if (reg_addr_in == PTX_OFS_NEXT_ADDR)
      rdata_next = next_addr_reg;
    else if (reg_addr_in == PTX_OFS_LAST_WORD)
      rdata_next = last_word_reg;
    else if (reg_addr_in == PTX_OFS_COUNTS)
      rdata_next = {bytes_done_reg, packets_done_reg};
    else if (reg_addr_in == PTX_OFS_FLAGS)
      rdata_next[PTX_FLAG_LSB +: PTX_FLAG_N] = flag_reg;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      rdata_reg <= PTX_ZERO_RESET;
    else if (reg_sel_in && !reg_write_in)
      rdata_reg <= rdata_next;
  end

  // writable registers; bad accesses alter only the error flags
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      pkt_size_reg <= 16'h0000;
      start_addr_reg <= PTX_ZERO_RESET;
      cmd_reg <= PTX_CMD_RESET;
      max_retry_reg <= 8'h00;
      max_beats_reg <= 8'h00;
    end
    else if (wr_ok)
    begin
      if (reg_addr_in == PTX_OFS_PKT_SIZE)
        pkt_size_reg <= (pkt_size_reg & ~be_mask[31:16]) | (reg_wdata_in[31:16] & be_mask[31:16]);
      if (reg_addr_in == PTX_OFS_START_ADDR)
        start_addr_reg <= (start_addr_reg & ~be_mask) | (reg_wdata_in & be_mask);
      if (reg_addr_in == PTX_OFS_XACT_CTL)
      begin
        if (reg_byte_en_in[3])
          cmd_reg <= reg_wdata_in[PTX_CMD_LSB +: 4];
        if (reg_byte_en_in[2])
          max_retry_reg <= reg_wdata_in[PTX_RETRY_LSB +: 8];
        if (reg_byte_en_in[1])
          max_beats_reg <= reg_wdata_in[PTX_BEATS_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ctl_reset_reg <= 1'b0;
      fifo_flush_reg <= 1'b0;
      auto_addr_reg <= 1'b0;
      berr_en_reg <= 1'b0;
      abort_ie_reg <= 1'b0;
      normal_ie_reg <= 1'b0;
      run_en_reg <= 1'b0;
    end
    else if (wr_ok && reg_addr_in == PTX_OFS_ENABLES && reg_byte_en_in[3])
    begin
      ctl_reset_reg <= reg_wdata_in[PTX_EN_RC];
      fifo_flush_reg <= reg_wdata_in[PTX_EN_RF];
      auto_addr_reg <= reg_wdata_in[PTX_EN_CM];
      berr_en_reg <= reg_wdata_in[PTX_EN_BERR];
      abort_ie_reg <= reg_wdata_in[PTX_EN_AIE];
      normal_ie_reg <= reg_wdata_in[PTX_EN_NIE];
      run_en_reg <= reg_wdata_in[PTX_EN_RUN];
    end
  end

  // sticky flags, set wins over clear
  assign flag_clr = (wr_ok && reg_addr_in == PTX_OFS_FLAGS)
                    ? (reg_wdata_in[PTX_FLAG_LSB +: PTX_FLAG_N] & be_mask[PTX_FLAG_LSB +: PTX_FLAG_N])
                    : '0;

  always_comb
  begin
    flag_set = '0;
    flag_set[PTX_F_NORMAL] = (state_reg == PTX_END);
    flag_set[PTX_F_RO_WRITE] = reg_sel_in && reg_write_in && hit_ro;
    flag_set[PTX_F_RSV_WRITE] = reg_sel_in && reg_write_in && hit_rsv;
    flag_set[PTX_F_RSV_READ] = reg_sel_in && !reg_write_in && hit_rsv;
    flag_set[PTX_F_FIFO] = fifo_fault_in;
    flag_set[PTX_F_ILLEGAL] = state_bad;
    flag_set[PTX_F_TRIES] = retry_over;
    flag_set[PTX_F_TGT_ABORT] = active && mst_target_abort_in;
    flag_set[PTX_F_INIT_ABORT] = active && mst_init_abort_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      flag_reg <= '0;
    else
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      irq_reg <= 1'b0;
    else
      irq_reg <= (abort_ie_reg && (|flag_reg[PTX_F_FIFO:PTX_F_INIT_ABORT]))
                 || (normal_ie_reg && flag_reg[PTX_F_NORMAL]);
  end

  // packet sequencing
  assign active = (state_reg == PTX_ADDR) || (state_reg == PTX_DATA);
  assign abort_evt = active && (mst_target_abort_in || mst_init_abort_in);
  assign retry_evt = active && mst_retry_in;
  assign state_bad = !(state_reg inside {PTX_IDLE, PTX_PLAN, PTX_ADDR, PTX_DATA, PTX_END});
  assign start_go = (state_reg == PTX_IDLE) && pending_reg && run_en_reg;
  assign remaining = {2'b00, pkt_size_reg[15:2]} - {2'b00, bytes_done_reg[15:2]};
  assign left_after = remaining - {15'h0000, beat_ok};
  assign burst_beats = (max_beats_reg == 8'h00) ? PTX_DEFAULT_BEATS : max_beats_reg;
  assign plan_beats = (remaining >= {8'h00, burst_beats}) ? burst_beats : 8'h01;
  assign beat_ok = (state_reg == PTX_DATA) && word_valid_reg && mst_data_ready_in;

  // a size write only counts with controller reset low
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || ctl_reset_reg)
      pending_reg <= 1'b0;
    else if (wr_ok && reg_addr_in == PTX_OFS_PKT_SIZE)
      pending_reg <= 1'b1;
    else if (start_go)
      pending_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || ctl_reset_reg)
      state_reg <= PTX_IDLE;
    else
    begin
      unique case (state_reg)
        PTX_IDLE:
          if (start_go)
            state_reg <= PTX_PLAN;
        PTX_PLAN:
          state_reg <= (remaining == 16'h0000) ? PTX_END : PTX_ADDR;
        PTX_ADDR:
          if (abort_evt || retry_over)
            state_reg <= PTX_IDLE;
          else if (run_en_reg && mst_req_ready_in && !mst_retry_in)
            state_reg <= PTX_DATA;
        PTX_DATA:
          if (abort_evt || retry_over)
            state_reg <= PTX_IDLE;
          else if (mst_retry_in)
            state_reg <= PTX_ADDR;
          else if (mst_done_in)
            state_reg <= (left_after == 16'h0000) ? PTX_END : PTX_PLAN;
        PTX_END:
          state_reg <= PTX_IDLE;
        default:
          state_reg <= PTX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || ctl_reset_reg)
      beats_left_reg <= 8'h00;
    else if (state_reg == PTX_PLAN)
      beats_left_reg <= plan_beats;
    else if (beat_ok)
      beats_left_reg <= beats_left_reg - 8'h01;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      next_addr_reg <= PTX_ZERO_RESET;
    else if (ctl_reset_reg)
      next_addr_reg <= start_addr_reg;
    else if (start_go && !auto_addr_reg)
      next_addr_reg <= start_addr_reg;
    else if (beat_ok)
      next_addr_reg <= next_addr_reg + {16'h0000, PTX_BYTES_PER_BEAT};
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || start_go)
      bytes_done_reg <= 16'h0000;
    else if (state_reg == PTX_END && auto_addr_reg)
      bytes_done_reg <= 16'h0000;
    else if (beat_ok)
      bytes_done_reg <= bytes_done_reg + PTX_BYTES_PER_BEAT;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || ctl_reset_reg || !run_en_reg)
      packets_done_reg <= 16'h0000;
    else if (state_reg == PTX_END && auto_addr_reg)
      packets_done_reg <= packets_done_reg + 16'h0001;
  end

  // word holding stage toward the PCI master
  assign out_s.ready = (state_reg == PTX_DATA) && !ctl_reset_reg
                       && (word_valid_reg ? (beat_ok && beats_left_reg > 8'h01)
                                          : (beats_left_reg != 8'h00));
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || ctl_reset_reg || abort_evt || retry_over)
    begin
      word_valid_reg <= 1'b0;
      word_reg <= PTX_ZERO_RESET;
    end
    else if (pop)
    begin
      word_valid_reg <= 1'b1;
      word_reg <= out_s.data;
    end
    else if (beat_ok)
      word_valid_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      last_word_reg <= PTX_ZERO_RESET;
    else if (pop)
      last_word_reg <= out_s.data;
  end

  assign in_s.valid = word_valid_in;
  assign in_s.data = word_data_in;

  ptx_fifo #(.W(PTX_WORD_W), .DEPTH(PTX_FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .flush_in(fifo_flush_reg),
    .wr(in_s),
    .rd(out_s)
  );

  ptx_retry_guard u_retry (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in || ctl_reset_reg),
    .restart_in(state_reg == PTX_PLAN),
    .retry_in(retry_evt),
    .limit_in(max_retry_reg),
    .exceeded_out(retry_over)
  );

  // outputs
  assign word_ready_out = in_s.ready;
  assign fifo_flush_out = fifo_flush_reg;
  assign reg_rdata_out = rdata_reg;
  assign reg_ack_out = ack_reg;
  assign transfer_error_ack_n_out = tea_n_reg;
  assign irq_out = irq_reg;
  assign mst_req_out = (state_reg == PTX_ADDR) && run_en_reg && !ctl_reset_reg;
  assign mst_cmd_out = cmd_reg;
  assign mst_addr_out = next_addr_reg;
  assign mst_beats_out = beats_left_reg;
  assign mst_data_out = word_reg;
  assign mst_data_valid_out = (state_reg == PTX_DATA) && word_valid_reg;
endmodule
`default_nettype wire

// File: inc/ptx_pkg.sv
package ptx_pkg;
  // register byte offsets
  localparam logic [15:0] PTX_OFS_PKT_SIZE = 16'h3800;
  localparam logic [15:0] PTX_OFS_START_ADDR = 16'h3804;
  localparam logic [15:0] PTX_OFS_XACT_CTL = 16'h3808;
  localparam logic [15:0] PTX_OFS_ENABLES = 16'h380c;
  localparam logic [15:0] PTX_OFS_NEXT_ADDR = 16'h3810;
  localparam logic [15:0] PTX_OFS_LAST_WORD = 16'h3814;
  localparam logic [15:0] PTX_OFS_COUNTS = 16'h3818;
  localparam logic [15:0] PTX_OFS_FLAGS = 16'h381c;
  localparam int PTX_WIN_LSB = 6;
  // field positions (bit 0 = lsb)
  localparam int PTX_PKT_SIZE_LSB = 16;
  localparam int PTX_CMD_LSB = 24;
  localparam int PTX_RETRY_LSB = 16;
  localparam int PTX_BEATS_LSB = 8;
  localparam int PTX_EN_RC = 31;
  localparam int PTX_EN_RF = 30;
  localparam int PTX_EN_CM = 28;
  localparam int PTX_EN_BERR = 27;
  localparam int PTX_EN_AIE = 26;
  localparam int PTX_EN_NIE = 25;
  localparam int PTX_EN_RUN = 24;
  localparam int PTX_BYTES_LSB = 16;
  localparam int PTX_FLAG_LSB = 16;
  localparam int PTX_FLAG_N = 9;
  // flag index within the flag field
  localparam int PTX_F_INIT_ABORT = 0;
  localparam int PTX_F_TGT_ABORT = 1;
  localparam int PTX_F_TRIES = 2;
  localparam int PTX_F_ILLEGAL = 3;
  localparam int PTX_F_FIFO = 4;
  localparam int PTX_F_RSV_READ = 5;
  localparam int PTX_F_RSV_WRITE = 6;
  localparam int PTX_F_RO_WRITE = 7;
  localparam int PTX_F_NORMAL = 8;
  // reset values
  localparam logic [3:0] PTX_CMD_RESET = 4'h7;
  localparam logic [31:0] PTX_ZERO_RESET = 32'h0000_0000;
  // transfer constants
  localparam logic [7:0] PTX_DEFAULT_BEATS = 8'h08;
  localparam logic [7:0] PTX_RETRY_UNLIMITED = 8'hff;
  localparam logic [15:0] PTX_BYTES_PER_BEAT = 16'h0004;
  localparam int PTX_WORD_W = 32;
  localparam int PTX_FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    PTX_IDLE = 3'b000,
    PTX_PLAN = 3'b001,
    PTX_ADDR = 3'b010,
    PTX_DATA = 3'b011,
    PTX_END = 3'b100
  } ptx_state_e;
endpackage

// File: inc/ptx_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ptx_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hdl/ptx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ptx_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic flush_in,
  // streams
  ptx_stream_if.snk wr,
  ptx_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign wr.ready = (count_reg != (AW+1)'(DEPTH));
  assign rd.valid = (count_reg != '0);
  assign rd.data = mem_reg[rd_ptr_reg];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  always_ff @(posedge clk_sys_in)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= wr.data;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || flush_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: hdl/ptx_retry_guard.sv
`timescale 1ns/1ps
`default_nettype none
module ptx_retry_guard
  import ptx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // control
  input wire logic restart_in,
  input wire logic retry_in,
  input wire logic [7:0] limit_in,
  // result
  output logic exceeded_out
);
  logic [7:0] count_reg;

  // counts retries of one transaction only
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in || restart_in)
      count_reg <= 8'h00;
    else if (retry_in && count_reg != 8'hff)
      count_reg <= count_reg + 8'h01;
  end

  assign exceeded_out = retry_in && (limit_in != 8'h00) && (limit_in != PTX_RETRY_UNLIMITED)
                        && (count_reg >= limit_in);
endmodule
`default_nettype wire

// File: verif/ptx_dma_ctl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ptx_dma_ctl_monitor
  import ptx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // register bus
  input wire logic reg_sel_in,
  input wire logic reg_write_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [3:0] reg_byte_en_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_ack_out,
  input wire logic transfer_error_ack_n_out,
  // master side
  input wire logic fifo_flush_out,
  input wire logic mst_req_out,
  input wire logic [31:0] mst_addr_out,
  input wire logic [7:0] mst_beats_out,
  input wire logic mst_req_ready_in,
  input wire logic [31:0] mst_data_out,
  input wire logic mst_data_valid_out,
  input wire logic mst_data_ready_in,
  input wire logic mst_retry_in,
  input wire logic mst_target_abort_in,
  input wire logic mst_init_abort_in,
  input wire logic irq_out
);
  logic [7:0] en_reg;
  logic en_wr;
  assign en_wr = reg_sel_in && reg_write_in && reg_addr_in == PTX_OFS_ENABLES && reg_byte_en_in[3];
  // shadow of the enable byte
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      en_reg <= 8'h00;
    else if (en_wr)
      en_reg <= reg_wdata_in[31:24];
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  a_one_answer: assert property (reg_sel_in |=> reg_ack_out != !transfer_error_ack_n_out)
    else $error("access not answered exactly once");
  a_quiet_bus: assert property (!reg_sel_in |=> !reg_ack_out && transfer_error_ack_n_out)
    else $error("answer without access");
  a_error_gated: assert property (reg_sel_in && !en_reg[3] |=> transfer_error_ack_n_out)
    else $error("error answer while reporting off");
  a_ro_write_err: assert property (reg_sel_in && reg_write_in && reg_addr_in == PTX_OFS_NEXT_ADDR
    && en_reg[3] |=> !transfer_error_ack_n_out)
    else $error("read-only write not refused");
  a_flush_follows: assert property (en_wr |=> fifo_flush_out == $past(reg_wdata_in[30]))
    else $error("flush output wrong");
  a_send_gated: assert property (mst_req_out |-> en_reg[0] && !en_reg[7])
    else $error("request while stopped");
  a_req_stands: assert property (mst_req_out && !mst_req_ready_in |=> mst_req_out
    && $stable(mst_addr_out) && $stable(mst_beats_out))
    else $error("request dropped or changed");
  a_beat_stands: assert property (mst_data_valid_out && !mst_data_ready_in && !mst_retry_in
    && !mst_target_abort_in && !mst_init_abort_in |=>
    mst_data_valid_out && $stable(mst_data_out))
    else $error("beat dropped or changed");
  a_addr_step: assert property (mst_data_valid_out && mst_data_ready_in |=>
    mst_addr_out == $past(mst_addr_out) + 32'h0000_0004)
    else $error("address not advanced by four");
  a_beats_range: assert property (mst_req_out |-> mst_beats_out inside {[8'h01:8'h08]})
    else $error("beat count out of range");
  a_irq_enabled: assert property ($rose(irq_out) |-> en_reg[2] || en_reg[1])
    else $error("interrupt without enable");
endmodule
bind ptx_dma_ctl ptx_dma_ctl_monitor mon (.*);
`default_nettype wire

// File: verif/ptx_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptx_master_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // from the block
  input wire logic req_in,
  input wire logic [7:0] beats_in,
  input wire logic data_valid_in,
  // scenario control
  input wire logic slow_in,
  input wire logic [1:0] fault_in,
  // answers
  output logic req_ready_out,
  output logic data_ready_out,
  output logic done_out,
  output logic [2:0] term_out
);
  logic busy_reg;
  logic tick_reg;
  logic [7:0] left_reg;
  assign data_ready_out = busy_reg && (!slow_in || tick_reg);
  always @(posedge clk_sys_in)
  begin
    req_ready_out <= 1'b0;
    done_out <= 1'b0;
    term_out <= 3'b000;
    tick_reg <= !tick_reg;
    if (reset_in)
    begin
      busy_reg <= 1'b0;
      tick_reg <= 1'b0;
    end
    else if (req_ready_out && req_in)
    begin
      if (fault_in == 2'b00)
      begin
        busy_reg <= 1'b1;
        left_reg <= beats_in;
      end
      else
        term_out <= 3'b100 >> (fault_in - 2'b01);
    end
    else if (busy_reg && data_valid_in && data_ready_out)
    begin
      left_reg <= left_reg - 8'h01;
      if (left_reg == 8'h01)
      begin
        busy_reg <= 1'b0;
        done_out <= 1'b1;
      end
    end
    else if (req_in && !busy_reg && (!slow_in || tick_reg))
      req_ready_out <= 1'b1;
  end
endmodule
`default_nettype wire

// File: verif/test_ptx_dma_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module test_ptx_dma_ctl;
  import ptx_pkg::*;
  logic clk_sys_in = 0, reset_in = 1, reg_sel_in = 0, reg_write_in = 0, word_valid_in = 0;
  logic fifo_fault_in = 0, slow = 0, full_seen = 0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [3:0] reg_byte_en_in = 4'hf;
  logic [31:0] reg_wdata_in = 0, word_data_in = 0, rd, reg_rdata_out, mst_addr_out, mst_data_out;
  logic [1:0] fault = 0, rsp;
  logic [3:0] mst_cmd_out;
  logic [7:0] mst_beats_out;
  logic [2:0] term;
  logic reg_ack_out, transfer_error_ack_n_out, word_ready_out, fifo_flush_out, mst_req_out;
  logic mst_req_ready_in, mst_data_valid_out, mst_data_ready_in, mst_done_in, irq_out;
  logic mst_retry_in, mst_target_abort_in, mst_init_abort_in;
  int errors = 0, comparisons = 0, cycles = 0;
  assign {mst_retry_in, mst_target_abort_in, mst_init_abort_in} = term;
  ptx_dma_ctl dut (.*);
  ptx_master_model far (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .req_in(mst_req_out),
    .beats_in(mst_beats_out), .data_valid_in(mst_data_valid_out), .slow_in(slow),
    .fault_in(fault), .req_ready_out(mst_req_ready_in), .data_ready_out(mst_data_ready_in),
    .done_out(mst_done_in), .term_out(term));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (!word_ready_out && !reset_in)
      full_seen <= 1;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_sel_in <= 1;
    reg_write_in <= w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_sel_in <= 0;
    #1 rd = reg_rdata_out;
    rsp = {reg_ack_out, transfer_error_ack_n_out};
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    acc(0, a, 0);
    chk(rd, exp);
  endtask
  task automatic push(input int n, input logic [31:0] base);
    for (int i = 0; i < n; i++)
    begin
      word_data_in <= base + i;
      word_valid_in <= 1;
      do @(posedge clk_sys_in); while (!word_ready_out);
    end
    word_valid_in <= 0;
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 3000 && irq_out !== 1'b1; k++) @(posedge clk_sys_in);
    chk(irq_out, 1);
  endtask
  task automatic s_regs_and_errors();
    for (int i = 0; i < 5; i++) rchk(PTX_OFS_ENABLES + 16'(4 * i), 0);
    acc(0, 16'h3820, 0);
    chk(rsp, 2'b11);
    acc(1, PTX_OFS_ENABLES, 32'h0800_0000);
    acc(1, PTX_OFS_NEXT_ADDR, 32'h1234_5678);
    chk(rsp, 2'b00);
    acc(1, 16'h3824, 32'hffff_ffff);
    chk(rsp, 2'b00);
    rchk(PTX_OFS_FLAGS, 32'h00e0_0000);
    rchk(PTX_OFS_NEXT_ADDR, 0);
    acc(1, PTX_OFS_FLAGS, 32'h0080_0000);
    rchk(PTX_OFS_FLAGS, 32'h0060_0000);
    acc(1, PTX_OFS_FLAGS, 32'hffff_0000);
  endtask
  task automatic s_packet();
    acc(1, PTX_OFS_START_ADDR, 32'h0000_1000);
    acc(1, PTX_OFS_XACT_CTL, 32'h0700_0000);
    acc(1, PTX_OFS_ENABLES, 32'h0300_0000);
    slow <= 1;
    acc(1, PTX_OFS_PKT_SIZE, 32'h002b_0000);
    push(10, 32'ha000_0000);
    wait_irq();
    rchk(PTX_OFS_COUNTS, 32'h0028_0000);
    rchk(PTX_OFS_NEXT_ADDR, 32'h0000_1028);
    rchk(PTX_OFS_LAST_WORD, 32'ha000_0009);
    rchk(PTX_OFS_FLAGS, 32'h0100_0000);
    acc(1, PTX_OFS_FLAGS, 32'hffff_0000);
    @(posedge clk_sys_in);
    #1 chk(irq_out, 0);
    chk(full_seen, 1);
    slow <= 0;
  endtask
  task automatic s_auto();
    acc(1, PTX_OFS_START_ADDR, 32'h0000_5000);
    acc(1, PTX_OFS_ENABLES, 32'h1300_0000);
    for (int p = 1; p < 3; p++)
    begin
      acc(1, PTX_OFS_PKT_SIZE, 32'h0008_0000);
      push(2, 32'(p) << 4);
      wait_irq();
      rchk(PTX_OFS_COUNTS, 32'(p));
      acc(1, PTX_OFS_FLAGS, 32'hffff_0000);
    end
    rchk(PTX_OFS_NEXT_ADDR, 32'h0000_1038);
    acc(1, PTX_OFS_ENABLES, 32'h1000_0000);
    rchk(PTX_OFS_COUNTS, 0);
    acc(1, PTX_OFS_PKT_SIZE, 32'h0004_0000);
    push(1, 32'h0000_00c1);
    repeat (20) @(posedge clk_sys_in);
    rchk(PTX_OFS_NEXT_ADDR, 32'h0000_1038);
    acc(1, PTX_OFS_ENABLES, 32'h1300_0000);
    wait_irq();
    rchk(PTX_OFS_NEXT_ADDR, 32'h0000_103c);
    acc(1, PTX_OFS_FLAGS, 32'hffff_0000);
  endtask
  task automatic s_faults();
    logic [31:0] exp[4] = '{32'h0004_0000, 32'h0002_0000, 32'h0001_0000, 32'h0010_0000};
    acc(1, PTX_OFS_XACT_CTL, 32'h0701_0000);
    for (int m = 1; m < 5; m++)
    begin
      acc(1, PTX_OFS_START_ADDR, 32'h0000_2000);
      acc(1, PTX_OFS_ENABLES, 32'hc000_0000);
      rchk(PTX_OFS_ENABLES, 32'hc000_0000);
      chk(mst_cmd_out, 32'h0000_0007);
      rchk(PTX_OFS_NEXT_ADDR, 32'h0000_2000);
      acc(1, PTX_OFS_ENABLES, 32'h0500_0000);
      if (m < 4)
      begin
        fault <= 2'(m);
        acc(1, PTX_OFS_PKT_SIZE, 32'h0004_0000);
        push(1, 32'hbad0_0000);
      end
      else
      begin
        fifo_fault_in <= 1;
        @(posedge clk_sys_in);
        fifo_fault_in <= 0;
      end
      wait_irq();
      rchk(PTX_OFS_FLAGS, exp[m - 1]);
      rchk(PTX_OFS_NEXT_ADDR, 32'h0000_2000);
      fault <= 0;
      acc(1, PTX_OFS_FLAGS, 32'hffff_0000);
      rchk(PTX_OFS_FLAGS, 0);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 0;
    s_regs_and_errors();
    s_packet();
    s_auto();
    s_faults();
    report_and_stop();
  end
endmodule
`default_nettype wire
